// ==== core/ppde_pkg.sv ====
// Package with register map, field masks and reset values of the pin direction enables
package ppde_pkg;
  localparam int PPDE_DW = 8;
  localparam int PPDE_AW = 16;
  // Printed offsets are consecutive, not spaced by four: they are indices, byte address is four times
  localparam logic [PPDE_AW-1:0] PPDE_IDX_PORTF_OE = 16'h30B5;
  localparam logic [PPDE_AW-1:0] PPDE_IDX_PORTG_OE = 16'h30B6;
  localparam logic [PPDE_AW-1:0] PPDE_IDX_PORTH_OE = 16'h30B7;
  localparam logic [PPDE_AW-1:0] PPDE_IDX_PORTA_IE = 16'h30B8;
  localparam int PPDE_PAW = 18;
  localparam logic [PPDE_PAW-1:0] PPDE_ADDR_PORTF_OE = {PPDE_IDX_PORTF_OE, 2'b00};
  localparam logic [PPDE_PAW-1:0] PPDE_ADDR_PORTG_OE = {PPDE_IDX_PORTG_OE, 2'b00};
  localparam logic [PPDE_PAW-1:0] PPDE_ADDR_PORTH_OE = {PPDE_IDX_PORTH_OE, 2'b00};
  localparam logic [PPDE_PAW-1:0] PPDE_ADDR_PORTA_IE = {PPDE_IDX_PORTA_IE, 2'b00};
  // Masks of implemented bits; others read zero and ignore writes
  localparam logic [PPDE_DW-1:0] PPDE_MASK_PORTF = 8'hFF;
  localparam logic [PPDE_DW-1:0] PPDE_MASK_PORTG = 8'h0F;
  localparam logic [PPDE_DW-1:0] PPDE_MASK_PORTH = 8'hC7;
  localparam logic [PPDE_DW-1:0] PPDE_MASK_PORTA = 8'hEF;
  localparam logic [PPDE_DW-1:0] PPDE_RESET_VAL = 8'h00;
  localparam logic [31:0] PPDE_RDATA_ZERO = 32'h0000_0000;
endpackage : ppde_pkg

// ==== core/ppde_regs.sv ====
// APB register block holding port F/G/H output enables and port A input enables
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Port F eight read/write drive enables
// - Port G bits 3..0 read/write drive enables
// - Port H bits 7,6,2,1,0 drive enables
// - Port A bits 7,6,5,3..0 input enables
// - Unimplemented bits read-only, always read zero
// - Registers at indices 30B5h..30B8h, in order
module ppde_regs
  import ppde_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PPDE_PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PPDE_DW-1:0] portf_drive_on,
  output logic [PPDE_DW-1:0] portg_drive_on,
  output logic [PPDE_DW-1:0] porth_drive_on,
  output logic [PPDE_DW-1:0] porta_input_on
);

  // Register state; pad outputs are these flops directly
  logic [PPDE_DW-1:0] portf_q;
  logic [PPDE_DW-1:0] portg_q;
  logic [PPDE_DW-1:0] porth_q;
  logic [PPDE_DW-1:0] porta_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Address decode
  wire sel_f = (paddr == PPDE_ADDR_PORTF_OE);
  wire sel_g = (paddr == PPDE_ADDR_PORTG_OE);
  wire sel_h = (paddr == PPDE_ADDR_PORTH_OE);
  wire sel_a = (paddr == PPDE_ADDR_PORTA_IE);
  wire hit = sel_f | sel_g | sel_h | sel_a;
  // Setup phase seen: answer is registered so pready is high in the first access cycle
  wire setup = psel & ~penable;
  wire acc_done = psel & penable & pready_q;
  wire wr_en = acc_done & pwrite & hit & pstrb[0];
  wire [PPDE_DW-1:0] wbyte = pwdata[PPDE_DW-1:0];

  // Write data masked to implemented bits
  wire [PPDE_DW-1:0] portf_d = wbyte & PPDE_MASK_PORTF;
  wire [PPDE_DW-1:0] portg_d = wbyte & PPDE_MASK_PORTG;
  wire [PPDE_DW-1:0] porth_d = wbyte & PPDE_MASK_PORTH;
  wire [PPDE_DW-1:0] porta_d = wbyte & PPDE_MASK_PORTA;

  // Read mux; reserved bits are zero because the flops never hold them
  wire [PPDE_DW-1:0] rbyte = sel_f ? portf_q :
                             sel_g ? portg_q :
                             sel_h ? porth_q :
                             sel_a ? porta_q : PPDE_RESET_VAL;
  wire [31:0] rdata_d = {24'h000000, rbyte};

  // Enable registers: whole byte loads in one access edge
  always_ff @(posedge clk) begin
    if (srst) begin
      portf_q <= PPDE_RESET_VAL;
      portg_q <= PPDE_RESET_VAL;
      porth_q <= PPDE_RESET_VAL;
      porta_q <= PPDE_RESET_VAL;
    end else if (wr_en) begin
      if (sel_f) portf_q <= portf_d;
      if (sel_g) portg_q <= portg_d;
      if (sel_h) porth_q <= porth_d;
      if (sel_a) porta_q <= porta_d;
    end
  end

  // APB answer: no wait state, error on unmapped address
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= PPDE_RDATA_ZERO;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      prdata_q <= (setup & ~pwrite) ? rdata_d : PPDE_RDATA_ZERO;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign portf_drive_on = portf_q;
  assign portg_drive_on = portg_q;
  assign porth_drive_on = porth_q;
  assign porta_input_on = porta_q;

  // Checks
  property p_f_write;
    @(posedge clk) disable iff (srst)
      (wr_en && sel_f) |=> (portf_drive_on == ($past(pwdata[PPDE_DW-1:0]) & PPDE_MASK_PORTF));
  endproperty
  a_f_write: assert property (p_f_write) else $error("port F enable not loaded");

  property p_g_write;
    @(posedge clk) disable iff (srst)
      (wr_en && sel_g) |=> (portg_drive_on == ($past(pwdata[PPDE_DW-1:0]) & PPDE_MASK_PORTG));
  endproperty
  a_g_write: assert property (p_g_write) else $error("port G enable wrong");

  property p_h_write;
    @(posedge clk) disable iff (srst)
      (wr_en && sel_h) |=> (porth_drive_on == ($past(pwdata[PPDE_DW-1:0]) & PPDE_MASK_PORTH));
  endproperty
  a_h_write: assert property (p_h_write) else $error("port H enable wrong");

  property p_a_write;
    @(posedge clk) disable iff (srst)
      (wr_en && sel_a) |=> (porta_input_on == ($past(pwdata[PPDE_DW-1:0]) & PPDE_MASK_PORTA));
  endproperty
  a_a_write: assert property (p_a_write) else $error("port A enable wrong");

  property p_reserved_zero;
    @(posedge clk) disable iff (srst)
      (portg_drive_on[7:4] == 4'h0) && (porth_drive_on[5:3] == 3'h0) && !porta_input_on[4];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_read_back;
    @(posedge clk) disable iff (srst)
      (setup && !pwrite && paddr == PPDE_ADDR_PORTH_OE) |=> (prdata[7:0] == porth_drive_on);
  endproperty
  a_read_back: assert property (p_read_back) else $error("port H readback wrong");

  property p_unmapped;
    @(posedge clk) disable iff (srst)
      (setup && !hit) |=> (pready && pslverr && prdata == PPDE_RDATA_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_hold;
    @(posedge clk) disable iff (srst)
      !wr_en |=> $stable(portf_drive_on) && $stable(porta_input_on);
  endproperty
  a_hold: assert property (p_hold) else $error("enable changed without write");

  // Reset clears every enable; no disable here so the clear itself is watched
  property p_reset_clear;
    @(posedge clk)
      srst |=> (portf_drive_on == PPDE_RESET_VAL) && (portg_drive_on == PPDE_RESET_VAL) &&
               (porth_drive_on == PPDE_RESET_VAL) && (porta_input_on == PPDE_RESET_VAL);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not cleared");

  // Each register holds unless its own address is written
  property p_f_hold;
    @(posedge clk) disable iff (srst)
      !(wr_en && sel_f) |=> $stable(portf_drive_on);
  endproperty
  a_f_hold: assert property (p_f_hold) else $error("port F enable changed");

  property p_g_hold;
    @(posedge clk) disable iff (srst)
      !(wr_en && sel_g) |=> $stable(portg_drive_on);
  endproperty
  a_g_hold: assert property (p_g_hold) else $error("port G enable changed");

  property p_h_hold;
    @(posedge clk) disable iff (srst)
      !(wr_en && sel_h) |=> $stable(porth_drive_on);
  endproperty
  a_h_hold: assert property (p_h_hold) else $error("port H enable changed");

  property p_a_hold;
    @(posedge clk) disable iff (srst)
      !(wr_en && sel_a) |=> $stable(porta_input_on);
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("port A enable changed");

  // A cleared strobe must leave every enable untouched
  property p_strobe_off;
    @(posedge clk) disable iff (srst)
      (acc_done && pwrite && !pstrb[0]) |=> $stable(portf_drive_on) &&
        $stable(portg_drive_on) && $stable(porth_drive_on) && $stable(porta_input_on);
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("write without strobe landed");

  // Writes to a hole in the map land nowhere
  property p_unmapped_write;
    @(posedge clk) disable iff (srst)
      (acc_done && pwrite && !hit) |=> $stable(portf_drive_on) &&
        $stable(portg_drive_on) && $stable(porth_drive_on) && $stable(porta_input_on);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed");

  // Read back of the other three registers, low lane only
  property p_read_f;
    @(posedge clk) disable iff (srst)
      (setup && !pwrite && sel_f) |=> (prdata[PPDE_DW-1:0] == portf_drive_on);
  endproperty
  a_read_f: assert property (p_read_f) else $error("port F readback wrong");

  property p_read_g;
    @(posedge clk) disable iff (srst)
      (setup && !pwrite && sel_g) |=> (prdata[PPDE_DW-1:0] == portg_drive_on);
  endproperty
  a_read_g: assert property (p_read_g) else $error("port G readback wrong");

  property p_read_a;
    @(posedge clk) disable iff (srst)
      (setup && !pwrite && sel_a) |=> (prdata[PPDE_DW-1:0] == porta_input_on);
  endproperty
  a_read_a: assert property (p_read_a) else $error("port A readback wrong");

  // Upper lanes carry nothing, so software never sees stale bits there
  property p_upper_zero;
    @(posedge clk) disable iff (srst)
      pready |-> (prdata[31:PPDE_DW] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes not zero");

  // Writes return no data
  property p_write_rdata;
    @(posedge clk) disable iff (srst)
      (setup && pwrite) |=> (prdata == PPDE_RDATA_ZERO);
  endproperty
  a_write_rdata: assert property (p_write_rdata) else $error("read data on a write");

  // Handshake shape: one wait-free access, pready a single-cycle pulse
  property p_setup_ready;
    @(posedge clk) disable iff (srst)
      setup |=> pready;
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");

  property p_ready_pulse;
    @(posedge clk) disable iff (srst)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_ready_only_after_setup;
    @(posedge clk) disable iff (srst)
      !setup |=> !pready;
  endproperty
  a_ready_only_after_setup: assert property (p_ready_only_after_setup) else $error("spurious ready");

  // Error is only ever shown alongside the answer, and never for a mapped register
  property p_err_with_ready;
    @(posedge clk) disable iff (srst)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_mapped_ok;
    @(posedge clk) disable iff (srst)
      (setup && hit) |=> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("error on mapped register");

  // Per-bit view of port F: each pin's enable follows only its own data bit
  for (genvar b = 0; b < PPDE_DW; b++) begin : g_portf_bit
    property p_f_bit;
      @(posedge clk) disable iff (srst)
        (wr_en && sel_f) |=> (portf_drive_on[b] == $past(pwdata[b]));
    endproperty
    a_f_bit: assert property (p_f_bit) else $error("port F enable bit not loaded");
  end

  // Main scenarios worth seeing at least once
  c_write_f: cover property (@(posedge clk) disable iff (srst) wr_en && sel_f);
  c_write_h: cover property (@(posedge clk) disable iff (srst) wr_en && sel_h);
  c_strobe_off: cover property (@(posedge clk) disable iff (srst) acc_done && pwrite && !pstrb[0]);
  c_read_a: cover property (@(posedge clk) disable iff (srst) acc_done && !pwrite && sel_a);
  c_unmapped: cover property (@(posedge clk) disable iff (srst) acc_done && !hit);

endmodule : ppde_regs

`default_nettype wire

// ==== tb/ppde_regs_tb.sv ====
// Self-checking bench for the pin direction enable registers over APB
`timescale 1ns/10ps
`default_nettype none
module ppde_regs_tb;
  import ppde_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [PPDE_PAW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = 4'h0;
  logic [PPDE_DW-1:0] portf_drive_on, portg_drive_on, porth_drive_on, porta_input_on;
  logic [PPDE_PAW-1:0] adr [4] = '{PPDE_ADDR_PORTF_OE, PPDE_ADDR_PORTG_OE,
                                   PPDE_ADDR_PORTH_OE, PPDE_ADDR_PORTA_IE};
  logic [7:0] msk [4] = '{PPDE_MASK_PORTF, PPDE_MASK_PORTG, PPDE_MASK_PORTH, PPDE_MASK_PORTA};
  int fail_count = 0, samples_checked = 0;
  ppde_regs u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portf_drive_on(portf_drive_on), .portg_drive_on(portg_drive_on),
    .porth_drive_on(porth_drive_on), .porta_input_on(porta_input_on));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  function automatic logic [31:0] pad(input int i);
    return {24'h0, i == 0 ? portf_drive_on : i == 1 ? portg_drive_on :
            i == 2 ? porth_drive_on : porta_input_on};
  endfunction : pad
  // Leaves psel/penable up; a back-to-back call re-drives psel and lowers penable for its own setup
  task automatic apb(input logic w, input logic [PPDE_PAW-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fail_count++;
      tally_and_finish();
    end else begin
      r = prdata;
      e = pslverr;
    end
  endtask : apb
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : idle
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0, 4'h0);
      chk("reset read", 32'h0, r);
      chk("reset pad", 32'h0, pad(i));
    end
    idle();
  endtask : t_reset
  task automatic t_rw();
    logic [31:0] p [3] = '{32'hFFFF_FFFF, 32'h0000_00A5, 32'h0000_005A};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        apb(1'b1, adr[i], p[j], 4'h1);
        #1 chk("pad", {24'h0, p[j][7:0] & msk[i]}, pad(i));
        apb(1'b0, adr[i], 32'h0, 4'h0);
        chk("read", {24'h0, p[j][7:0] & msk[i]}, r);
      end
    end
    idle();
  endtask : t_rw
  task automatic t_map();
    for (int i = 0; i < 4; i++) apb(1'b1, adr[i], 32'h0000_00F0 >> i, 4'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0, 4'h0);
      chk("map read", {24'h0, 8'hF0 >> i & msk[i]}, r);
    end
    idle();
  endtask : t_map
  task automatic t_refuse();
    apb(1'b1, {16'h30B9, 2'b00}, 32'h0000_00FF, 4'h1);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b0, {16'h30B4, 2'b00}, 32'h0, 4'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped read", 32'h0, r);
    apb(1'b1, adr[0], 32'h0000_000F, 4'h0);
    #1 chk("strobe off pad", 32'hF0, pad(0));
    idle();
  endtask : t_refuse
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_map();
    t_refuse();
    tally_and_finish();
  end
endmodule : ppde_regs_tb
`default_nettype wire
